/* File: rtl/board_ctrl_regs.sv */
// Control and status register bank of the pattern board
// What this block does
// - Clear register bit2 reads fault, write-1 clears
// - Set register bit2 reads fault, write-1 forces
// - Enable register bit2 gates fault interrupt
// - Bit0 flags register access timeout
// - Array power fault sets fault interrupt
// - Status register shows six live flags
// - Bit0 picks DIP switch or register flags
// - Bit1 quad row load, resets one
// - Bit2 flips array top and bottom
// - Bit3 one disables reset timer
// - Bit4 inverts pixels, sent to controller
// - Bit7 one floats mirrors, resets zero
// - Bit8 enables external trigger global reset
// - Bits7:0 select one of sixteen images
// - Bit8 enables cycling in test mode with loader enabled
// - Bits31:12 cycle period in milliseconds
// - Ones row used only within array rows
// - Loader reset style, global after reset
// - Array kind, firmware version, DIP levels
// - Buffer rows and start row setup
// - Burst length for host FIFO writes
`timescale 1ns/1ns
`default_nettype none
module board_ctrl_regs #(
	parameter int CYCLES_PER_MS = board_regs_pkg::MS_CYCLES
) (
	input  wire logic        i_mclk,
	input  wire logic        i_reset_n,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [31:0] i_reg_wdata,
	input  wire logic        i_reg_rtaken,
	output logic [31:0]      o_reg_rdata,
	output logic             o_reg_rvalid,
	input  wire logic        i_array_fault,
	input  wire logic        i_calib_active,
	input  wire logic        i_ctrl_finished,
	input  wire logic        i_array_reset_active,
	input  wire logic        i_sys_pll_locked,
	input  wire logic        i_ref_pll_locked,
	input  wire logic [3:0]  i_array_kind,
	input  wire logic [2:0]  i_fw_version,
	input  wire logic [7:0]  i_config_dip_switch,
	input  wire logic [10:0] i_array_rows,
	input  wire logic        i_test_image_mode,
	input  wire logic        i_loader_enable,
	output logic             o_fault_irq_n,
	output logic             o_quad_row_load,
	output logic             o_vertical_flip_enable,
	output logic             o_reset_timer_disable,
	output logic             o_invert_pixels,
	output logic             o_mirror_release,
	output logic             o_ext_trigger_reset,
	output logic [7:0]       o_image_code,
	output logic [10:0]      o_ones_row,
	output logic             o_ones_row_valid,
	output logic [3:0]       o_loader_reset_style,
	output logic [10:0]      o_buf_rows,
	output logic [15:0]      o_buf_start_row,
	output logic [9:0]       o_burst_length
);
	logic        fault_pend_ff;
	logic        tmo_ff;
	logic        fault_en_ff;
	logic [8:0]  mirror_ctl_ff;
	logic [7:0]  image_code_ff;
	logic        cycle_en_ff;
	logic [19:0] period_ff;
	logic [10:0] ones_row_ff;
	logic [3:0]  rst_style_ff;
	logic [10:0] buf_rows_ff;
	logic [15:0] buf_start_ff;
	logic [9:0]  burst_ff;
	logic [15:0] rd_wait_ff;
	logic [31:0] nxt_rdata;
	logic        rd_expire;
	logic        wr_clear;
	logic        wr_force;
	logic        wr_mask;
	logic        wr_ctl;
	logic        wr_image;
	logic        line_active;
	logic [8:0]  eff_ctl;

	cycle_if cyc ();

	image_cycle_timer #(
		.CYCLES_PER_MS(CYCLES_PER_MS)
	) u_cycle (
		.i_mclk   (i_mclk),
		.i_reset_n(i_reset_n),
		.cyc      (cyc.timer)
	);

	assign wr_clear = i_reg_wr && i_reg_addr == board_regs_pkg::IRQ_CLEAR_OFS;
	assign wr_force = i_reg_wr && i_reg_addr == board_regs_pkg::IRQ_FORCE_OFS;
	assign wr_mask  = i_reg_wr && i_reg_addr == board_regs_pkg::IRQ_MASK_OFS;
	assign wr_ctl   = i_reg_wr && i_reg_addr == board_regs_pkg::MIRROR_CTL_OFS;
	assign wr_image = i_reg_wr && i_reg_addr == board_regs_pkg::IMAGE_SEL_OFS;
	assign line_active = fault_pend_ff && fault_en_ff;

	// Fault pending: hardware fault and software force win over clear
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n)
			fault_pend_ff <= 1'b0;
		else if (i_array_fault)
			fault_pend_ff <= 1'b1;
		else if (wr_force && i_reg_wdata[board_regs_pkg::FAULT_BIT])
			fault_pend_ff <= 1'b1;
		else if (wr_clear && i_reg_wdata[board_regs_pkg::FAULT_BIT])
			fault_pend_ff <= 1'b0;
	end

	// Timeout flag: a lost read answer sets it, set wins over clear
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n)
			tmo_ff <= 1'b0;
		else if (rd_expire || (wr_force && i_reg_wdata[board_regs_pkg::TMO_BIT]))
			tmo_ff <= 1'b1;
		else if (wr_clear && i_reg_wdata[board_regs_pkg::TMO_BIT])
			tmo_ff <= 1'b0;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			fault_en_ff <= 1'b0;
		end else if (wr_mask) begin
			fault_en_ff <= i_reg_wdata[board_regs_pkg::FAULT_BIT];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n)
			o_fault_irq_n <= 1'b1;
		else
			o_fault_irq_n <= !line_active;
	end

	// Mirror control flags, undefined bits 6:5 stay zero
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n)
			mirror_ctl_ff <= board_regs_pkg::MIRROR_CTL_RST;
		else if (wr_ctl)
			mirror_ctl_ff <= i_reg_wdata[8:0] & 9'h19f;
	end

	// DIP switch bit n stands in for control bit n; no switch for bit 8
	always_comb begin
		eff_ctl = mirror_ctl_ff;
		if (!mirror_ctl_ff[board_regs_pkg::CTL_SRC_BIT])
			eff_ctl = {1'b0, i_config_dip_switch & 8'h9e};
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			o_quad_row_load        <= 1'b1;
			o_vertical_flip_enable <= 1'b0;
			o_reset_timer_disable  <= 1'b1;
			o_invert_pixels        <= 1'b0;
			o_mirror_release       <= 1'b0;
			o_ext_trigger_reset    <= 1'b0;
		end else begin
			o_quad_row_load        <= eff_ctl[board_regs_pkg::QUAD_BIT];
			o_vertical_flip_enable <= eff_ctl[board_regs_pkg::FLIP_BIT];
			o_reset_timer_disable  <= eff_ctl[board_regs_pkg::TIMER_DIS_BIT];
			o_invert_pixels        <= eff_ctl[board_regs_pkg::INVERT_BIT];
			o_mirror_release       <= eff_ctl[board_regs_pkg::RELEASE_BIT];
			o_ext_trigger_reset    <= eff_ctl[board_regs_pkg::EXT_TRIG_BIT];
		end
	end

	// Cycling steps through the sixteen images; a write wins over a step
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			image_code_ff <= board_regs_pkg::IMAGE_CODE_RST;
			cycle_en_ff   <= board_regs_pkg::CYCLE_EN_RST;
			period_ff     <= board_regs_pkg::PERIOD_RST;
		end else if (wr_image) begin
			image_code_ff <= i_reg_wdata[7:0];
			cycle_en_ff   <= i_reg_wdata[board_regs_pkg::CYCLE_EN_BIT];
			period_ff     <= i_reg_wdata[31:board_regs_pkg::PERIOD_LSB];
		end else if (cyc.step && cyc.run) begin
			image_code_ff <= {4'h0, image_code_ff[3:0] + 4'h1};
		end
	end

	assign cyc.run       = cycle_en_ff && i_test_image_mode && i_loader_enable;
	assign cyc.period_ms = period_ff;

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n)
			o_image_code <= board_regs_pkg::IMAGE_CODE_RST;
		else
			o_image_code <= image_code_ff;
	end

	// Setup fields; the loader must be stopped by software around style changes
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			ones_row_ff  <= 11'h000;
			rst_style_ff <= board_regs_pkg::RST_STYLE_RST;
			buf_rows_ff  <= 11'h000;
			buf_start_ff <= 16'h0000;
			burst_ff     <= 10'h000;
		end else if (i_reg_wr) begin
			unique case (i_reg_addr)
				board_regs_pkg::ONES_ROW_OFS: ones_row_ff <= i_reg_wdata[10:0];
				board_regs_pkg::RST_STYLE_OFS: rst_style_ff <= i_reg_wdata[3:0];
				board_regs_pkg::BUF_SETUP_OFS: begin
					buf_rows_ff  <= i_reg_wdata[10:0];
					buf_start_ff <= i_reg_wdata[31:board_regs_pkg::BUF_ROW_LSB];
				end
				board_regs_pkg::BURST_LEN_OFS: burst_ff <= i_reg_wdata[9:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			o_ones_row           <= 11'h000;
			o_ones_row_valid     <= 1'b0;
			o_loader_reset_style <= board_regs_pkg::RST_STYLE_RST;
			o_buf_rows           <= 11'h000;
			o_buf_start_row      <= 16'h0000;
			o_burst_length       <= 10'h000;
		end else begin
			o_ones_row           <= ones_row_ff;
			o_ones_row_valid     <= ones_row_ff < i_array_rows;
			o_loader_reset_style <= rst_style_ff;
			o_buf_rows           <= buf_rows_ff;
			o_buf_start_row      <= buf_start_ff;
			o_burst_length       <= burst_ff;
		end
	end

	// Read mux; unmapped offsets and undefined bits read zero
	always_comb begin
		nxt_rdata = 32'h00000000;
		unique case (i_reg_addr)
			board_regs_pkg::IRQ_CLEAR_OFS,
			board_regs_pkg::IRQ_FORCE_OFS: begin
				nxt_rdata[board_regs_pkg::FAULT_BIT] = fault_pend_ff;
				nxt_rdata[board_regs_pkg::TMO_BIT]   = tmo_ff;
			end
			board_regs_pkg::IRQ_MASK_OFS: begin
				// Timeout flag shows here as well; it has no enable of its own
				nxt_rdata[board_regs_pkg::FAULT_BIT] = fault_en_ff;
				nxt_rdata[board_regs_pkg::TMO_BIT]   = tmo_ff;
			end
			board_regs_pkg::STATUS_OFS:
				nxt_rdata[5:0] = {i_ref_pll_locked, i_sys_pll_locked, i_array_reset_active,
					line_active, i_ctrl_finished, i_calib_active};
			board_regs_pkg::MIRROR_CTL_OFS: nxt_rdata[8:0] = mirror_ctl_ff;
			board_regs_pkg::IMAGE_SEL_OFS:
				nxt_rdata = {period_ff, 3'h0, cycle_en_ff, image_code_ff};
			board_regs_pkg::ONES_ROW_OFS: nxt_rdata[10:0] = ones_row_ff;
			board_regs_pkg::RST_STYLE_OFS: nxt_rdata[3:0] = rst_style_ff;
			board_regs_pkg::KIND_INFO_OFS:
				nxt_rdata = {i_config_dip_switch, 17'h00000, i_fw_version, i_array_kind};
			board_regs_pkg::BUF_SETUP_OFS:
				nxt_rdata = {buf_start_ff, 5'h00, buf_rows_ff};
			board_regs_pkg::BURST_LEN_OFS: nxt_rdata[9:0] = burst_ff;
			default: nxt_rdata = 32'h00000000;
		endcase
	end

	// An answer left untaken is dropped so the port cannot hang
	assign rd_expire = o_reg_rvalid && !i_reg_rtaken && !i_reg_rd &&
		rd_wait_ff == 16'(board_regs_pkg::RD_TIMEOUT_CYC - 1);

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			o_reg_rdata  <= 32'h00000000;
			o_reg_rvalid <= 1'b0;
			rd_wait_ff   <= 16'h0000;
		end else if (i_reg_rd) begin
			o_reg_rdata  <= nxt_rdata;
			o_reg_rvalid <= 1'b1;
			rd_wait_ff   <= 16'h0000;
		end else if (i_reg_rtaken || rd_expire) begin
			o_reg_rvalid <= 1'b0;
			rd_wait_ff   <= 16'h0000;
		end else if (o_reg_rvalid) begin
			rd_wait_ff <= rd_wait_ff + 16'h0001;
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);

	fault_sets_pend_a: assert property (i_array_fault |=> fault_pend_ff)
		else $error("array fault did not set pending");
	clear_drops_pend_a: assert property (
		wr_clear && i_reg_wdata[2] && !i_array_fault && !(wr_force && i_reg_wdata[2])
		|=> !fault_pend_ff)
		else $error("fault clear ignored");
	force_sets_pend_a: assert property (wr_force && i_reg_wdata[2] |=> fault_pend_ff)
		else $error("fault force ignored");
	irq_line_gate_a: assert property (fault_pend_ff && fault_en_ff |=> !o_fault_irq_n)
		else $error("fault line not driven");
	irq_disabled_a: assert property (!fault_en_ff |=> o_fault_irq_n)
		else $error("fault line active while disabled");
	mask_write_a: assert property (wr_mask |=> fault_en_ff == $past(i_reg_wdata[2]))
		else $error("fault enable not stored");
	read_timeout_a: assert property (
		i_reg_rd ##1 (!i_reg_rtaken && !i_reg_rd) [*8] |-> o_reg_rvalid)
		else $error("read answer dropped early");
	timeout_flag_a: assert property (rd_expire |=> tmo_ff && !o_reg_rvalid)
		else $error("timeout not flagged");
	tmo_clear_a: assert property (wr_clear && i_reg_wdata[0] && !rd_expire |=> !tmo_ff)
		else $error("timeout clear ignored");
	dip_source_a: assert property (
		!mirror_ctl_ff[0] |=> o_quad_row_load == $past(i_config_dip_switch[1]))
		else $error("dip switch not used");
	reg_source_a: assert property (
		mirror_ctl_ff[0] |=> o_invert_pixels == $past(mirror_ctl_ff[4]))
		else $error("invert flag not from register");
	cycle_hold_a: assert property (!cyc.run && !wr_image |=> $stable(image_code_ff))
		else $error("image changed while cycling is off");
	cycle_step_a: assert property (
		cyc.step && cyc.run && !wr_image |=> image_code_ff[3:0] == $past(image_code_ff[3:0]) + 4'h1)
		else $error("image did not advance");
	row_limit_a: assert property (
		ones_row_ff >= i_array_rows |=> !o_ones_row_valid)
		else $error("row beyond limit used");
	ro_write_a: assert property (
		i_reg_wr && i_reg_addr == board_regs_pkg::STATUS_OFS |=> $stable(mirror_ctl_ff))
		else $error("read-only write changed state");

	fault_clear_c: cover property (fault_pend_ff ##1 wr_clear ##1 !fault_pend_ff);
	timeout_c: cover property (rd_expire);
	cycle_c: cover property (cyc.step && cyc.run);
	read_c: cover property (i_reg_rd ##1 o_reg_rvalid ##[1:4] i_reg_rtaken);
	force_line_c: cover property (wr_force && i_reg_wdata[2] && fault_en_ff ##2 !o_fault_irq_n);
endmodule
`default_nettype wire

/* File: rtl/board_regs_pkg.sv */
// Constants for the pattern board control register bank
package board_regs_pkg;
	localparam logic [7:0] IRQ_CLEAR_OFS   = 8'h00;
	localparam logic [7:0] IRQ_FORCE_OFS   = 8'h04;
	localparam logic [7:0] IRQ_MASK_OFS    = 8'h08;
	localparam logic [7:0] STATUS_OFS      = 8'h0c;
	localparam logic [7:0] MIRROR_CTL_OFS  = 8'h10;
	localparam logic [7:0] IMAGE_SEL_OFS   = 8'h14;
	localparam logic [7:0] ONES_ROW_OFS    = 8'h18;
	localparam logic [7:0] RST_STYLE_OFS   = 8'h1c;
	localparam logic [7:0] KIND_INFO_OFS   = 8'h20;
	localparam logic [7:0] BUF_SETUP_OFS   = 8'h24;
	localparam logic [7:0] BURST_LEN_OFS   = 8'h28;
	localparam int TMO_BIT       = 0;
	localparam int FAULT_BIT     = 2;
	localparam int CTL_SRC_BIT   = 0;
	localparam int QUAD_BIT      = 1;
	localparam int FLIP_BIT      = 2;
	localparam int TIMER_DIS_BIT = 3;
	localparam int INVERT_BIT    = 4;
	localparam int RELEASE_BIT   = 7;
	localparam int EXT_TRIG_BIT  = 8;
	localparam int CYCLE_EN_BIT  = 8;
	localparam int PERIOD_LSB    = 12;
	localparam int BUF_ROW_LSB   = 16;
	localparam logic [8:0] MIRROR_CTL_RST = 9'h00a;
	localparam logic [7:0] IMAGE_CODE_RST = 8'h00;
	localparam logic       CYCLE_EN_RST   = 1'b1;
	localparam logic [19:0] PERIOD_RST    = 20'd2000;
	localparam logic [3:0] RST_STYLE_RST  = 4'h2;
	localparam logic [3:0] STYLE_SINGLE   = 4'h0;
	localparam logic [3:0] STYLE_DUAL     = 4'h1;
	localparam logic [3:0] STYLE_GLOBAL   = 4'h2;
	localparam logic [3:0] STYLE_QUAD     = 4'h3;
	localparam logic [3:0] IMAGE_NOISE    = 4'hd;
	localparam logic [3:0] IMAGE_USER     = 4'hf;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
	localparam int RD_TIMEOUT_NS = 2560;
	localparam int RD_TIMEOUT_CYC = RD_TIMEOUT_NS / CLK_PERIOD_NS;
endpackage

/* File: rtl/cycle_if.sv */
// Link between register bank and test image cycle timer
`timescale 1ns/1ns
`default_nettype none
interface cycle_if;
	logic        run;
	logic [19:0] period_ms;
	logic        step;
	modport timer (input run, input period_ms, output step);
	modport user (output run, output period_ms, input step);
endinterface
`default_nettype wire

/* File: rtl/image_cycle_timer.sv */
// Millisecond period timer that paces test image cycling
`timescale 1ns/1ns
`default_nettype none
module image_cycle_timer #(
	parameter int CYCLES_PER_MS = board_regs_pkg::MS_CYCLES
) (
	input  wire logic i_mclk,
	input  wire logic i_reset_n,
	cycle_if.timer    cyc
);
	logic [23:0] tick_ff;
	logic [19:0] ms_ff;
	logic        step_ff;
	logic        ms_done;

	assign ms_done  = (tick_ff == 24'(CYCLES_PER_MS - 1));
	assign cyc.step = step_ff;

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n || !cyc.run || ms_done)
			tick_ff <= 24'h000000;
		else
			tick_ff <= tick_ff + 24'h000001;
	end

	// A zero period is treated as one millisecond
	always_ff @(posedge i_mclk) begin
		step_ff <= 1'b0;
		if (!i_reset_n || !cyc.run) begin
			ms_ff <= 20'h00000;
		end else if (ms_done) begin
			if (ms_ff + 20'h00001 >= cyc.period_ms) begin
				ms_ff   <= 20'h00000;
				step_ff <= 1'b1;
			end else begin
				ms_ff <= ms_ff + 20'h00001;
			end
		end
	end

	step_spacing_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		step_ff |=> !step_ff)
		else $error("cycle step lasted more than one cycle");
endmodule
`default_nettype wire

/* File: testbench/reg_host_model.sv */
// Host side master for the register strobe port
`timescale 1ns/1ns
`default_nettype none
module reg_host_model (
	input  wire logic        i_mclk,
	input  wire logic [31:0] i_rdata,
	input  wire logic        i_rvalid,
	output logic             o_wr,
	output logic             o_rd,
	output logic [7:0]       o_addr,
	output logic [31:0]      o_wdata,
	output logic             o_rtaken
);
	initial begin
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_addr <= 8'h00;
		o_wdata <= 32'h0;
		o_rtaken <= 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_mclk);
		o_wr <= 1'b0;
		// Stale data must never look like a fresh write
		o_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, input logic take, output logic [31:0] d);
		int n;
		@(posedge i_mclk);
		o_rd <= 1'b1;
		o_addr <= a;
		@(posedge i_mclk);
		o_rd <= 1'b0;
		#1;
		n = 0;
		while (i_rvalid !== 1'b1 && n < 8) begin
			@(posedge i_mclk);
			#1;
			n++;
		end
		d = (i_rvalid === 1'b1) ? i_rdata : 32'hxxxx_xxxx;
		if (take) begin
			@(posedge i_mclk);
			o_rtaken <= 1'b1;
			@(posedge i_mclk);
			o_rtaken <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

/* File: testbench/tb_board_ctrl_regs.sv */
// Self-checking bench for the pattern board register bank
`timescale 1ns/1ns
`default_nettype none
module tb_board_ctrl_regs;
	logic        i_mclk, i_reset_n, i_reg_wr, i_reg_rd, i_reg_rtaken, o_reg_rvalid;
	logic [7:0]  i_reg_addr, i_config_dip_switch, o_image_code;
	logic [31:0] i_reg_wdata, o_reg_rdata;
	logic        i_array_fault, i_calib_active, i_ctrl_finished, i_array_reset_active;
	logic        i_sys_pll_locked, i_ref_pll_locked, i_test_image_mode, i_loader_enable;
	logic [3:0]  i_array_kind, o_loader_reset_style;
	logic [2:0]  i_fw_version;
	logic [10:0] i_array_rows, o_ones_row, o_buf_rows;
	logic        o_fault_irq_n, o_quad_row_load, o_vertical_flip_enable, o_reset_timer_disable;
	logic        o_invert_pixels, o_mirror_release, o_ext_trigger_reset, o_ones_row_valid;
	logic [15:0] o_buf_start_row;
	logic [9:0]  o_burst_length;
	logic [5:0]  flags;
	int          n_fail = 0;
	int          n_checks = 0;
	assign flags = {o_ext_trigger_reset, o_mirror_release, o_invert_pixels, o_reset_timer_disable,
		o_vertical_flip_enable, o_quad_row_load};
	board_ctrl_regs #(.CYCLES_PER_MS(10)) u_board_ctrl_regs (.i_mclk, .i_reset_n, .i_reg_wr, .i_reg_rd,
		.i_reg_addr, .i_reg_wdata, .i_reg_rtaken, .o_reg_rdata, .o_reg_rvalid, .i_array_fault,
		.i_calib_active, .i_ctrl_finished, .i_array_reset_active, .i_sys_pll_locked, .i_ref_pll_locked,
		.i_array_kind, .i_fw_version, .i_config_dip_switch, .i_array_rows, .i_test_image_mode,
		.i_loader_enable, .o_fault_irq_n, .o_quad_row_load, .o_vertical_flip_enable,
		.o_reset_timer_disable, .o_invert_pixels, .o_mirror_release, .o_ext_trigger_reset,
		.o_image_code, .o_ones_row, .o_ones_row_valid, .o_loader_reset_style, .o_buf_rows,
		.o_buf_start_row, .o_burst_length);
	reg_host_model u_reg_host_model (.i_mclk, .i_rdata(o_reg_rdata), .i_rvalid(o_reg_rvalid),
		.o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata),
		.o_rtaken(i_reg_rtaken));
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		u_reg_host_model.rd(a, 1'b1, d);
		chk(d, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_reg_host_model.wr(a, d);
	endtask
	task automatic wait_chg(input logic [7:0] old, output int n);
		n = 0;
		while (o_image_code === old && n < 60) begin
			@(posedge i_mclk);
			#1;
			n++;
		end
	endtask
	task automatic t_reset;
		rchk(8'h00, 32'h0);
		rchk(8'h10, 32'h0000_000a);
		rchk(8'h14, 32'h007d_0100);
		rchk(8'h1c, 32'h2);
		rchk(8'h2c, 32'h0);
		chk(32'(o_fault_irq_n), 32'h1);
		chk({26'h0, flags}, 32'h0);
	endtask
	task automatic t_status;
		logic [4:0] p;
		for (int i = 0; i < 2; i++) begin
			p = i ? 5'h0a : 5'h15;
			@(posedge i_mclk);
			{i_ref_pll_locked, i_sys_pll_locked, i_array_reset_active, i_ctrl_finished, i_calib_active} <= p;
			i_array_kind <= p[3:0];
			i_fw_version <= p[2:0];
			i_config_dip_switch <= {p, p[2:0]};
			rchk(8'h0c, {26'h0, p[4:2], 1'b0, p[1:0]});
			rchk(8'h20, {p, p[2:0], 17'h0, p[2:0], p[3:0]});
		end
		wr(8'h0c, 32'hffff_ffff);
		rchk(8'h0c, 32'h12);
	endtask
	task automatic t_ctrl;
		@(posedge i_mclk);
		i_config_dip_switch <= 8'h96;
		wr(8'h10, 32'h0000_01fe);
		rchk(8'h10, 32'h0000_019e);
		chk({26'h0, flags}, 32'h1b);
		wr(8'h10, 32'hffff_ffff);
		rchk(8'h10, 32'h0000_019f);
		chk({26'h0, flags}, 32'h3f);
		wr(8'h10, 32'h1);
		rchk(8'h10, 32'h1);
		chk({26'h0, flags}, 32'h0);
	endtask
	task automatic t_fault;
		wr(8'h08, 32'h4);
		rchk(8'h08, 32'h4);
		@(posedge i_mclk);
		i_array_fault <= 1'b1;
		// Clear loses while the fault level stays high
		wr(8'h00, 32'h4);
		rchk(8'h00, 32'h4);
		rchk(8'h0c, 32'h16);
		chk(32'(o_fault_irq_n), 32'h0);
		@(posedge i_mclk);
		i_array_fault <= 1'b0;
		wr(8'h00, 32'h4);
		rchk(8'h00, 32'h0);
		chk(32'(o_fault_irq_n), 32'h1);
		wr(8'h04, 32'h4);
		rchk(8'h04, 32'h4);
		chk(32'(o_fault_irq_n), 32'h0);
		wr(8'h08, 32'h0);
		rchk(8'h00, 32'h4);
		chk(32'(o_fault_irq_n), 32'h1);
		wr(8'h00, 32'h4);
	endtask
	task automatic t_fields;
		for (int i = 0; i < 3; i++) begin
			wr(8'h18, 32'hffff_f800 | (1078 + i));
			rchk(8'h18, 32'(1078 + i));
			chk({20'h0, o_ones_row_valid, o_ones_row}, {20'h0, i < 2, 11'(1078 + i)});
		end
		@(posedge i_mclk);
		i_loader_enable <= 1'b0;
		for (int i = 3; i >= 0; i--) begin
			wr(8'h1c, 32'hffff_fff0 | i);
			rchk(8'h1c, 32'(i));
			chk(32'(o_loader_reset_style), 32'(i));
		end
		@(posedge i_mclk);
		i_loader_enable <= 1'b1;
		wr(8'h24, 32'habcd_ffff);
		rchk(8'h24, 32'habcd_07ff);
		chk({o_buf_start_row, 5'h0, o_buf_rows}, 32'habcd_07ff);
		wr(8'h28, 32'hffff_fdff);
		rchk(8'h28, 32'h1ff);
		chk(32'(o_burst_length), 32'h1ff);
	endtask
	task automatic t_cycle;
		int n;
		@(posedge i_mclk);
		i_test_image_mode <= 1'b1;
		wr(8'h14, 32'h0000_113e);
		repeat (2) @(posedge i_mclk);
		wait_chg(8'h3e, n);
		chk(32'(o_image_code), 32'h0f);
		wait_chg(8'h0f, n);
		chk(32'(o_image_code), 32'h00);
		chk(32'(n > 8 && n < 12), 32'h1);
		@(posedge i_mclk);
		i_loader_enable <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			wr(8'h14, 32'h0000_1100 | i);
			rchk(8'h14, 32'h0000_1100 | i);
			chk(32'(o_image_code), 32'(i));
		end
		// Cycling enabled but loader off: image must stay put
		repeat (40) @(posedge i_mclk);
		chk(32'(o_image_code), 32'h0f);
		@(posedge i_mclk);
		i_loader_enable <= 1'b1;
		i_test_image_mode <= 1'b0;
		repeat (40) @(posedge i_mclk);
		chk(32'(o_image_code), 32'h0f);
	endtask
	task automatic t_timeout;
		logic [31:0] d;
		int n;
		u_reg_host_model.rd(8'h1c, 1'b0, d);
		n = 0;
		while (o_reg_rvalid === 1'b1 && n < 400) begin
			@(posedge i_mclk);
			#1;
			n++;
		end
		chk(32'(n), 32'(board_regs_pkg::RD_TIMEOUT_CYC));
		rchk(8'h00, 32'h1);
		rchk(8'h04, 32'h1);
		rchk(8'h08, 32'h1);
		wr(8'h00, 32'h1);
		rchk(8'h00, 32'h0);
		wr(8'h04, 32'h1);
		rchk(8'h08, 32'h1);
		wr(8'h00, 32'h1);
		rchk(8'h04, 32'h0);
	endtask
	initial begin
		i_reset_n <= 1'b0;
		i_array_fault <= 1'b0;
		{i_calib_active, i_ctrl_finished, i_array_reset_active, i_sys_pll_locked, i_ref_pll_locked} <= 5'h0;
		i_array_kind <= 4'h0;
		i_fw_version <= 3'h0;
		i_config_dip_switch <= 8'h00;
		i_array_rows <= 11'd1080;
		i_test_image_mode <= 1'b0;
		i_loader_enable <= 1'b0;
		repeat (2) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		t_reset();
		t_status();
		t_ctrl();
		t_fault();
		t_fields();
		t_cycle();
		t_timeout();
		close_out();
	end
	initial begin
		// Whole run needs well under 3000 cycles
		repeat (10000) @(posedge i_mclk);
		n_fail++;
		close_out();
	end
endmodule
`default_nettype wire
